// ===== design/digital_pattern_playback.sv
// Purpose: Two-channel 16-bit digital pattern playback with bit table
// Assumes: One sample clock; sequencer supplies segment base and length
// Notes: Pattern loads pass a small FIFO that stalls on fetch cycles
`timescale 1ns/1ps
`include "playback_consts.svh"

// ****************************************************************
// Load FIFO
// ****************************************************************
module load_fifo #(
  parameter int W = 27,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// What this block does
// R1 - Two 16-bit differential ports, 32 bits total
// R2 - Select waveform memory or pattern memory source
// R3 - Waveform source mirrors waveform bits simultaneously; code takes them on fetch cycles only, output one clock later
// R4 - Pattern playback runs on the sample clock
// R5 - User supplies pattern length matching waveform
// R6 - Pattern segment length follows waveform segment
// R7 - Sequencer segment changes replay tied patterns
// R8 - Pattern advances at half sample rate
// R9 - Loads limited to half the segment size
// R10 - One global enable for all output bits
// R11 - One shared sample clock setting, three writers
// R12 - Common or per-bit high and low levels
// R13 - Common or per-bit delays from position
// R14 - Table edits take effect only on apply
// R15 - Table reset restores default bit settings
// R16 - Only 14 bits reach the level translator
// R17 - Table edits blocked without translator connected
// R18 - New word once per pattern cycle, edge-aligned
module digital_pattern_playback (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [`PB_CHANNELS-1:0] seg_restart,
  input wire logic [`PB_CHANNELS-1:0][`PB_SEG_W-1:0] seg_base,
  input wire logic [`PB_CHANNELS-1:0][`PB_SEG_W-1:0] seg_len,
  input wire playback_types_pkg::src_t src_sel,
  input wire logic [`PB_CHANNELS-1:0][`PB_WORD_W-1:0] wave_word,
  input wire logic out_enable,
  output logic [`PB_CHANNELS-1:0][`PB_WORD_W-1:0] dig_word,
  input wire logic load_valid,
  output logic load_ready,
  input wire playback_types_pkg::load_t load_data,
  output logic load_refused,
  input wire logic [2:0] sclk_wr,
  input wire logic [`PB_SCLK_W-1:0] sclk_value,
  output logic [`PB_SCLK_W-1:0] sclk_setting,
  input wire logic level_translator_box_present,
  input wire logic use_all_bits,
  input wire logic tbl_wr,
  input wire logic [`PB_BIT_IDX_W-1:0] tbl_bit,
  input wire playback_types_pkg::bit_cfg_t tbl_cfg,
  output logic tbl_wr_refused,
  input wire logic tbl_apply,
  input wire logic tbl_reset,
  input wire logic level_common,
  input wire logic delay_common,
  input wire logic [`PB_LVL_W-1:0] glob_low_mv,
  input wire logic [`PB_LVL_W-1:0] glob_high_mv,
  input wire logic [`PB_DLY_W-1:0] glob_delay_ps,
  output logic xlat_active,
  output logic [`PB_CHANNELS-1:0][`PB_XLAT_BITS-1:0] xlat_word,
  output playback_types_pkg::bit_cfg_t [`PB_XLAT_BITS-1:0] xlat_cfg
);
  localparam playback_types_pkg::bit_cfg_t CFG_RST =
    '{on: 1'b0, low_mv: `PB_LVL_LOW_RST, high_mv: `PB_LVL_HIGH_RST, delay_ps: `PB_DLY_RST};

  // ****************************************************************
  // Pin synchroniser and phase
  // ****************************************************************
  logic conn_meta_q;
  logic conn_q;
  playback_types_pkg::phase_t phase_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      conn_meta_q <= 1'b0;
      conn_q <= 1'b0;
    end else begin
      conn_meta_q <= level_translator_box_present;
      conn_q <= conn_meta_q;
    end
  end

  always_ff @(posedge clock) begin // R4
    if (!rst_n || !run) begin
      phase_q <= playback_types_pkg::PH_IDLE;
    end else begin
      case (phase_q)
        playback_types_pkg::PH_IDLE: phase_q <= playback_types_pkg::PH_FETCH;
        playback_types_pkg::PH_FETCH: phase_q <= playback_types_pkg::PH_HOLD; // R8
        playback_types_pkg::PH_HOLD: phase_q <= playback_types_pkg::PH_FETCH;
        default: phase_q <= playback_types_pkg::PH_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pattern memory and loading
  // ****************************************************************
  logic [`PB_WORD_W-1:0] pmem [`PB_CHANNELS][`PB_PMEM_DEPTH];
  playback_types_pkg::load_t ld;
  logic ld_valid;
  logic ld_take;
  logic ld_ok;
  logic [`PB_SEG_W-1:0] ld_half;

  load_fifo #(.W($bits(playback_types_pkg::load_t)), .DEPTH(`PB_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(load_valid),
    .in_ready(load_ready),
    .in_data(load_data),
    .out_valid(ld_valid),
    .out_ready(ld_take),
    .out_data(ld)
  );

  assign ld_take = (phase_q != playback_types_pkg::PH_FETCH);
  assign ld_half = seg_len[ld.ch] >> 1;
  assign ld_ok = ({1'b0, ld.addr} < ld_half); // R9

  always_ff @(posedge clock) begin
    if (ld_valid && ld_take && ld_ok) begin
      pmem[ld.ch][(`PB_PMEM_AW)'(seg_base[ld.ch] >> 1) + ld.addr] <= ld.data; // R6
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      load_refused <= 1'b0;
    end else begin
      load_refused <= ld_valid && ld_take && !ld_ok; // R9
    end
  end

  // ****************************************************************
  // Playback per channel
  // ****************************************************************
  logic [`PB_CHANNELS-1:0][`PB_SEG_W-1:0] ptr_q;
  logic [`PB_CHANNELS-1:0][`PB_WORD_W-1:0] word_q;

  for (genvar c = 0; c < `PB_CHANNELS; c++) begin : g_ch
    logic [`PB_SEG_W-1:0] half;
    logic [`PB_WORD_W-1:0] src_word;
    assign half = seg_len[c] >> 1; // R6
    assign src_word = (src_sel == playback_types_pkg::SRC_PATTERN) ? // R2
      pmem[c][(`PB_PMEM_AW)'((seg_base[c] >> 1) + ptr_q[c])] : wave_word[c]; // R3

    always_ff @(posedge clock) begin
      if (!rst_n || !run || seg_restart[c]) begin
        ptr_q[c] <= '0; // R7
      end else if (phase_q == playback_types_pkg::PH_FETCH) begin
        ptr_q[c] <= (ptr_q[c] + 1'b1 >= half) ? '0 : ptr_q[c] + 1'b1; // R8
      end
    end

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        word_q[c] <= '0;
      end else if (!out_enable) begin
        word_q[c] <= '0; // R10
      end else if (phase_q == playback_types_pkg::PH_FETCH) begin
        word_q[c] <= src_word; // R18
      end
    end
  end

  assign dig_word = word_q; // R1

  // ****************************************************************
  // Shared sample clock setting
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_setting <= `PB_SCLK_RST;
    end else if (|sclk_wr) begin
      sclk_setting <= sclk_value; // R11
    end
  end

  // ****************************************************************
  // Bit table: edit copy and applied copy
  // ****************************************************************
  playback_types_pkg::bit_cfg_t [`PB_WORD_W-1:0] edit_q;
  playback_types_pkg::bit_cfg_t [`PB_WORD_W-1:0] live_q;

  always_ff @(posedge clock) begin
    if (!rst_n || tbl_reset) begin
      edit_q <= {`PB_WORD_W{CFG_RST}}; // R15
    end else if (tbl_wr && conn_q) begin
      edit_q[tbl_bit] <= tbl_cfg; // R17
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || tbl_reset) begin
      live_q <= {`PB_WORD_W{CFG_RST}}; // R15
    end else if (tbl_apply) begin
      live_q <= edit_q; // R14
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tbl_wr_refused <= 1'b0;
    end else begin
      tbl_wr_refused <= tbl_wr && !conn_q && !tbl_reset; // R17
    end
  end

  // ****************************************************************
  // Translator outputs
  // ****************************************************************
  assign xlat_active = conn_q && !use_all_bits; // R16

  always_ff @(posedge clock) begin
    for (int b = 0; b < `PB_XLAT_BITS; b++) begin
      if (!rst_n) begin
        xlat_cfg[b] <= CFG_RST;
      end else begin
        xlat_cfg[b].on <= live_q[b].on;
        xlat_cfg[b].low_mv <= level_common ? glob_low_mv : live_q[b].low_mv; // R12
        xlat_cfg[b].high_mv <= level_common ? glob_high_mv : live_q[b].high_mv; // R12
        xlat_cfg[b].delay_ps <= delay_common ? glob_delay_ps : live_q[b].delay_ps; // R13
      end
    end
  end

  always_comb begin
    for (int c = 0; c < `PB_CHANNELS; c++) begin
      for (int b = 0; b < `PB_XLAT_BITS; b++) begin
        xlat_word[c][b] = xlat_active && xlat_cfg[b].on && word_q[c][b]; // R16
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_half_rate: assert property (@(posedge clock) disable iff (!rst_n) // R8
    $changed(dig_word) |-> $past(phase_q) == playback_types_pkg::PH_FETCH || !$past(out_enable))
    else $error("Word changed off the pattern cycle");
  chk_word_hold: assert property (@(posedge clock) disable iff (!rst_n) // R18
    (phase_q == playback_types_pkg::PH_HOLD && out_enable) |=> $stable(dig_word))
    else $error("Word not held for two sample clocks");
  chk_global_off: assert property (@(posedge clock) disable iff (!rst_n) // R10
    !out_enable |=> dig_word == '0)
    else $error("Outputs not switched off");
  chk_wave_mirror: assert property (@(posedge clock) disable iff (!rst_n) // R3
    (out_enable && phase_q == playback_types_pkg::PH_FETCH && src_sel == playback_types_pkg::SRC_WAVE)
    |=> dig_word == $past(wave_word))
    else $error("Waveform bits not mirrored");
  chk_apply_gate: assert property (@(posedge clock) disable iff (!rst_n) // R14
    (!tbl_apply && !tbl_reset) |=> $stable(live_q))
    else $error("Table changed without apply");
  chk_reset_dflt: assert property (@(posedge clock) disable iff (!rst_n) // R15
    tbl_reset |=> live_q[0] == CFG_RST && live_q[`PB_WORD_W-1] == CFG_RST)
    else $error("Table reset values wrong");
  chk_edit_block: assert property (@(posedge clock) disable iff (!rst_n) // R17
    (tbl_wr && !conn_q && !tbl_reset) |=> tbl_wr_refused && $stable(edit_q))
    else $error("Edit accepted without translator");
  chk_load_limit: assert property (@(posedge clock) disable iff (!rst_n) // R9
    (ld_valid && ld_take && !ld_ok) |=> load_refused)
    else $error("Load past half segment not refused");
  chk_sclk_shared: assert property (@(posedge clock) disable iff (!rst_n) // R11
    (|sclk_wr) |=> sclk_setting == $past(sclk_value))
    else $error("Sample clock setting not shared");
  chk_xlat_fixed: assert property (@(posedge clock) disable iff (!rst_n) // R16
    use_all_bits |-> xlat_word == '0)
    else $error("Translator driven in all-bits mode");
  chk_common_lvl: assert property (@(posedge clock) disable iff (!rst_n) // R12
    level_common |=> xlat_cfg[3].high_mv == $past(glob_high_mv))
    else $error("Common level not applied");
  chk_load_stall: assert property (@(posedge clock) disable iff (!rst_n)
    (phase_q == playback_types_pkg::PH_FETCH && ld_valid) |=> ld_valid)
    else $error("Load lost on fetch cycle");

  cov_pattern_play: cover property (@(posedge clock) disable iff (!rst_n)
    run && out_enable && src_sel == playback_types_pkg::SRC_PATTERN ##2 $changed(dig_word));
  cov_fifo_full: cover property (@(posedge clock) disable iff (!rst_n) !load_ready);
  cov_apply_edit: cover property (@(posedge clock) disable iff (!rst_n)
    tbl_wr && conn_q ##[1:8] tbl_apply);
  cov_seg_wrap: cover property (@(posedge clock) disable iff (!rst_n)
    phase_q == playback_types_pkg::PH_FETCH && ptr_q[0] != '0 ##1 ptr_q[0] == '0);
endmodule

// ===== design/playback_consts.svh
// Purpose: Constants of the digital pattern playback unit
// Assumes: 100 MHz sample clock, levels in mV, delays in ps
// Notes: Included by the type package, the design file and both bench files
`ifndef PLAYBACK_CONSTS_SVH
`define PLAYBACK_CONSTS_SVH

// ****************************************************************
// Widths and sizes
// ****************************************************************
`define PB_CHANNELS 2
`define PB_WORD_W 16
`define PB_XLAT_BITS 14
`define PB_BIT_IDX_W 4
`define PB_PMEM_DEPTH 1024
`define PB_PMEM_AW 10
`define PB_SEG_W 11
`define PB_LVL_W 12
`define PB_DLY_W 16
`define PB_SCLK_W 32
`define PB_FIFO_DEPTH 4

// ****************************************************************
// Reset values
// ****************************************************************
`define PB_LVL_LOW_RST 12'h000
`define PB_LVL_HIGH_RST 12'h1F4
`define PB_DLY_RST 16'h0000
`define PB_SCLK_RST 32'h05F5E100

`endif

// ===== design/playback_types_pkg.sv
// Purpose: Types shared by the digital pattern playback unit
// Assumes: Constants header on the include path
// Notes: Types only; numbers live in the header
`include "playback_consts.svh"

package playback_types_pkg;

  typedef struct packed {
    logic on;
    logic [`PB_LVL_W-1:0] low_mv;
    logic [`PB_LVL_W-1:0] high_mv;
    logic [`PB_DLY_W-1:0] delay_ps;
  } bit_cfg_t;

  typedef struct packed {
    logic ch;
    logic [`PB_PMEM_AW-1:0] addr;
    logic [`PB_WORD_W-1:0] data;
  } load_t;

  typedef enum logic {
    SRC_WAVE = 1'b0,
    SRC_PATTERN = 1'b1
  } src_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_FETCH = 2'b01,
    PH_HOLD = 2'b11
  } phase_t;

endpackage

// ===== dv/test_digital_pattern_playback.sv
// Purpose: Self-checking bench of the digital pattern playback unit
// Assumes: Inputs driven at the falling edge; fixed seed
// Notes: Patterns fill each segment to half its length
`timescale 1ns/1ps
`include "playback_consts.svh"

// ****************************************************************
// Bench
// ****************************************************************
module test_digital_pattern_playback;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic [1:0] seg_restart = '0;
  logic [1:0][10:0] seg_base = '0, seg_len = '0;
  playback_types_pkg::src_t src_sel = playback_types_pkg::SRC_WAVE;
  logic [1:0][15:0] wave_word = '0, dig_word;
  logic out_enable = 1'b0, load_valid = 1'b0, load_ready, load_refused;
  playback_types_pkg::load_t load_data = '0;
  logic [2:0] sclk_wr = '0;
  logic [31:0] sclk_value = '0, sclk_setting, prev;
  logic plugged = 1'b0, present, use_all_bits = 1'b0, tbl_wr = 1'b0, tbl_wr_refused;
  logic [3:0] tbl_bit = '0;
  playback_types_pkg::bit_cfg_t tbl_cfg = '0, dflt;
  logic tbl_apply = 1'b0, tbl_reset = 1'b0, level_common = 1'b0, delay_common = 1'b0;
  logic xlat_active;
  logic [11:0] glob_low_mv = '0, glob_high_mv = '0;
  logic [15:0] glob_delay_ps = '0;
  logic [1:0][13:0] xlat_word, bits_seen;
  playback_types_pkg::bit_cfg_t [13:0] xlat_cfg;
  logic [15:0] pat [0:5];
  int n_errors = 0, cmp_count = 0, seen;

  always #5 clock = ~clock;

  digital_pattern_playback i_digital_pattern_playback (
    .clock, .rst_n, .run, .seg_restart, .seg_base, .seg_len, .src_sel, .wave_word,
    .out_enable, .dig_word, .load_valid, .load_ready, .load_data, .load_refused,
    .sclk_wr, .sclk_value, .sclk_setting, .level_translator_box_present(present),
    .use_all_bits, .tbl_wr, .tbl_bit, .tbl_cfg, .tbl_wr_refused, .tbl_apply, .tbl_reset,
    .level_common, .delay_common, .glob_low_mv, .glob_high_mv, .glob_delay_ps,
    .xlat_active, .xlat_word, .xlat_cfg
  );

  xlat_box_model i_xlat_box_model (
    .clock, .plugged, .active(xlat_active), .bits_in(xlat_word), .present, .bits_seen
  );

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic pulse_see(ref logic s, ref logic r, input bit raise, output int c);
    c = 0;
    s = raise;
    repeat (4) begin
      tick(1);
      s = 1'b0;
      c += (r === 1'b1);
    end
  endtask

  task automatic load(input logic ch, input logic [9:0] a, input logic [15:0] d);
    load_data = '{ch, a, d};
    load_valid = 1'b1;
    while (load_ready !== 1'b1) tick(1);
    tick(1);
  endtask

  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  initial begin
    dflt = '{1'b0, `PB_LVL_LOW_RST, `PB_LVL_HIGH_RST, `PB_DLY_RST};
    seen = $urandom(42);
    tick(12);
    rst_n = 1'b1;
    tick(1);
    chk("sclk reset", 32'h05F5E100, sclk_setting);
    chk("cfg reset", dflt, xlat_cfg[0]);
    for (int i = 0; i < 3; i++) begin
      sclk_value = $urandom;
      sclk_wr[i] = 1'b1;
      tick(1);
      sclk_wr = '0;
      tick(1);
      chk("sclk_setting", sclk_value, sclk_setting);
    end
    $display("Test sample clock done");
    out_enable = 1'b1;
    run = 1'b1;
    for (int i = 0; i < 6; i++) begin
      wave_word = {16'($urandom), 16'($urandom)};
      tick(4);
      chk("wave mirror", wave_word, dig_word);
    end
    seen = 0;
    for (int i = 0; i < 16; i++) begin
      prev = dig_word;
      wave_word = wave_word + 32'h00010001;
      tick(1);
      seen += (dig_word !== prev);
    end
    chk("word changes", 48'h8, 48'(seen));
    out_enable = 1'b0;
    tick(2);
    chk("global off", 32'h0, dig_word);
    run = 1'b0;
    $display("Test waveform source done");
    seg_len = {11'h004, 11'h008};
    seg_base = {11'h004, 11'h000};
    for (int i = 0; i < 6; i++) begin
      pat[i] = 16'($urandom);
      load(i > 3, 10'(i > 3 ? i - 4 : i), pat[i]);
    end
    load(1'b0, 10'h004, 16'hFFFF);
    pulse_see(load_valid, load_refused, 1'b0, seen);
    chk("load refused", 48'h1, 48'(seen));
    src_sel = playback_types_pkg::SRC_PATTERN;
    out_enable = 1'b1;
    seg_restart = 2'b11;
    tick(1);
    seg_restart = '0;
    run = 1'b1;
    tick(2);
    for (int k = 0; k < 8; k++) begin
      chk("pattern ch0", pat[k % 4], dig_word[0]);
      chk("pattern ch1", pat[4 + k % 2], dig_word[1]);
      tick(2);
    end
    run = 1'b0;
    src_sel = playback_types_pkg::SRC_WAVE;
    $display("Test pattern source done");
    tbl_cfg = '{1'b1, 12'($urandom), 12'($urandom), 16'($urandom)};
    tbl_bit = 4'h3;
    pulse_see(tbl_wr, tbl_wr_refused, 1'b1, seen);
    chk("edit refused", 48'h1, 48'(seen));
    plugged = 1'b1;
    tick(4);
    pulse_see(tbl_wr, tbl_wr_refused, 1'b1, seen);
    chk("edit taken", 48'h0, 48'(seen));
    chk("before apply", dflt, xlat_cfg[3]);
    pulse_see(tbl_apply, tbl_wr_refused, 1'b1, seen);
    chk("after apply", tbl_cfg, xlat_cfg[3]);
    wave_word = '1;
    run = 1'b1;
    load(1'b1, 10'h000, pat[4]);
    load_valid = 1'b0;
    tick(6);
    chk("bit on", 48'h1, xlat_word[0][3]);
    chk("bit off", 48'h0, xlat_word[0][2]);
    chk("box sees", xlat_word, bits_seen);
    glob_low_mv = 12'($urandom);
    glob_high_mv = 12'($urandom);
    glob_delay_ps = 16'($urandom);
    level_common = 1'b1;
    delay_common = 1'b1;
    tick(3);
    chk("common low", glob_low_mv, xlat_cfg[3].low_mv);
    chk("common high", glob_high_mv, xlat_cfg[3].high_mv);
    chk("common delay", glob_delay_ps, xlat_cfg[3].delay_ps);
    use_all_bits = 1'b1;
    tick(2);
    chk("active", 48'h0, xlat_active);
    chk("xlat word", 48'h0, xlat_word);
    level_common = 1'b0;
    delay_common = 1'b0;
    pulse_see(tbl_reset, tbl_wr_refused, 1'b1, seen);
    chk("table reset", dflt, xlat_cfg[3]);
    $display("Test bit table done");
    close_out();
  end
endmodule

// ===== dv/xlat_box_model.sv
// Purpose: Level translator box model at the far side of the digital port
// Assumes: Presence pin is high while the box is plugged in
// Notes: Captures translated bits; drifts when translation is inactive
`timescale 1ns/1ps
`include "playback_consts.svh"

// ****************************************************************
// Translator box
// ****************************************************************
module xlat_box_model (
  input wire logic clock,
  input wire logic plugged,
  input wire logic active,
  input wire logic [`PB_CHANNELS-1:0][`PB_XLAT_BITS-1:0] bits_in,
  output logic present,
  output logic [`PB_CHANNELS-1:0][`PB_XLAT_BITS-1:0] bits_seen
);
  assign present = plugged;
  always_ff @(posedge clock) begin
    bits_seen <= active ? bits_in : ~bits_seen;
  end
endmodule
